// *** verilog/mcb_manager.sv ***
// Circular command and data buffer manager for the simple bus monitor.
// Assumes a decoder that hands over one message header, then its data words.
// What this block does
// - 48-bit mode: stamp bits 15:0, 31:16, 47:32 go to entry words 0, 1, 2.
// - Command entries start with word 0 at the lowest address, rising after.
// - Command writes stay between list words 0 and 2, rolling over at end.
// - Data writes stay between list words 4 and 6, rolling over at end.
// - Each recorded message updates both next-address list words.
// - Next-address pointers advance circularly, wrapping at the end boundary.
// - Writing the address in list word 3 or 7 raises its match interrupt.
// - List word 0 sits at the base register address; seven words follow.
// - Command entry is exactly 4 words (16-bit) or 8 words (48-bit).
// - Data entry length varies from 0 up to 35 words.
// - Configuration bits 1:0: 11 selects 16-bit, 01 selects 48-bit stamps.
// - 16-bit: status, stamp, data pointer, command in words 0 to 3.
// - 48-bit: status, gap, length bytes, data pointer, command in words 3 to 7.
// - RT-RT: receive command in entry, transmit command first data word.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module mcb_manager
  import mcb_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Message header from the decoder
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [15:0] msg_status,
  input wire logic [47:0] msg_time,
  input wire logic [15:0] msg_gap,
  input wire logic [15:0] msg_cmd,
  input wire logic [5:0] msg_len,
  // Message data words
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [15:0] word_data,
  // Interrupt
  output logic irq
);
  // ****************************************
  // Storage and state
  // ****************************************
  logic [15:0] ram [0:RAM_WORDS-1];
  logic [15:0] list [0:7];
  logic [15:0] ram_q;
  logic [15:0] eng_q;
  logic [15:0] cfg;
  logic [15:0] list_base;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [15:0] ram_addr;
  mcb_state_t state;
  mcb_state_t next_state;
  logic [3:0] lidx;
  logic [2:0] widx;
  logic [5:0] rem;
  logic [15:0] cptr;
  logic [15:0] dptr;
  logic [15:0] dblk;
  logic [15:0] h_status;
  logic [47:0] h_time;
  logic [15:0] h_gap;
  logic [15:0] h_cmd;
  logic [5:0] h_len;
  logic tt48;
  logic aw_hold;
  logic w_hold;
  logic rd_pend;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [11:0] araddr_q;

  // ****************************************
  // Register decode
  // ****************************************
  wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
  wire [7:0] widx_reg = awaddr_q[9:2];
  wire [7:0] ridx_reg = araddr_q[9:2];
  wire w_ok = awaddr_q[11:10] == 2'h0;
  wire r_ok = araddr_q[11:10] == 2'h0;
  wire wr_cfg = do_wr && w_ok && widx_reg == IDX_CFG;
  wire wr_base = do_wr && w_ok && widx_reg == IDX_LIST_BASE;
  wire wr_ist = do_wr && w_ok && widx_reg == IDX_IRQ_STATUS;
  wire wr_imsk = do_wr && w_ok && widx_reg == IDX_IRQ_MASK;
  wire wr_raddr = do_wr && w_ok && widx_reg == IDX_RAM_ADDR;
  wire wr_rdata = do_wr && w_ok && widx_reg == IDX_RAM_DATA;
  wire w_mapped = wr_cfg | wr_base | wr_ist | wr_imsk | wr_raddr | wr_rdata;
  wire [15:0] bmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] wd = wdata_q[15:0];
  wire r_mapped = r_ok && (ridx_reg == IDX_CFG || ridx_reg == IDX_LIST_BASE
    || ridx_reg == IDX_IRQ_STATUS || ridx_reg == IDX_IRQ_MASK
    || ridx_reg == IDX_RAM_ADDR || ridx_reg == IDX_RAM_DATA);
  wire [15:0] rmux =
    (ridx_reg == IDX_CFG) ? {cfg[15:9], state != ST_IDLE, cfg[7:0]} :
    (ridx_reg == IDX_LIST_BASE) ? list_base :
    (ridx_reg == IDX_IRQ_STATUS) ? {13'h0000, irq_status} :
    (ridx_reg == IDX_IRQ_MASK) ? {13'h0000, irq_mask} :
    (ridx_reg == IDX_RAM_ADDR) ? ram_addr :
    (ridx_reg == IDX_RAM_DATA) ? ram_q : 16'h0000;

  // ****************************************
  // Buffer engine datapath
  // ****************************************
  wire mode_ok = cfg[1:0] == MODE_TT16 || cfg[1:0] == MODE_TT48;
  wire msg_fire = msg_valid && msg_ready;
  wire word_fire = word_valid && word_ready;
  wire [2:0] last_w = tt48 ? LAST_W48 : LAST_W16;
  wire [15:0] cptr_inc = (cptr == list[LW_CMD_END]) ? list[LW_CMD_START] : cptr + 16'h0001;
  wire [15:0] dptr_inc = (dptr == list[LW_DAT_END]) ? list[LW_DAT_START] : dptr + 16'h0001;
  wire [15:0] eng_raddr = list_base + {12'h000, lidx};
  wire [15:0] len_bytes = {9'h000, h_len, 1'b0};
  logic [15:0] entry_word;
  always_comb begin
    entry_word = h_cmd;
    if (tt48) begin
      case (widx)
        3'h0: entry_word = h_time[15:0];
        3'h1: entry_word = h_time[31:16];
        3'h2: entry_word = h_time[47:32];
        3'h3: entry_word = h_status;
        3'h4: entry_word = h_gap;
        3'h5: entry_word = len_bytes;
        3'h6: entry_word = dblk;
        default: entry_word = h_cmd;
      endcase
    end else begin
      case (widx)
        3'h0: entry_word = h_status;
        3'h1: entry_word = h_time[15:0];
        3'h2: entry_word = dblk;
        default: entry_word = h_cmd;
      endcase
    end
  end
  // Data words come first so the data pointer is known before the entry
  wire data_we = state == ST_DATA && word_fire;
  wire cmd_we = state == ST_CMD;
  wire upc_we = state == ST_UPC;
  wire upd_we = state == ST_UPD;
  wire eng_we = data_we | cmd_we | upc_we | upd_we;
  wire [15:0] eng_waddr =
    data_we ? dptr :
    cmd_we ? cptr :
    upc_we ? list_base + {13'h0000, LW_CMD_NEXT} :
    list_base + {13'h0000, LW_DAT_NEXT};
  wire [15:0] eng_wdata = data_we ? word_data : cmd_we ? entry_word : upc_we ? cptr : dptr;
  wire cmd_hit = cmd_we && cptr == list[LW_CMD_IRQ];
  wire dat_hit = data_we && dptr == list[LW_DAT_IRQ];
  wire [2:0] irq_set = {upd_we, dat_hit, cmd_hit};
  wire [5:0] next_rem = (state == ST_LIST) ? h_len : (word_fire ? rem - 6'h01 : rem);

  always_comb begin
    case (state)
      ST_IDLE: next_state = msg_fire ? ST_LIST : ST_IDLE;
      ST_LIST: next_state = (lidx == LIST_LEN) ? ST_DATA : ST_LIST;
      ST_DATA: next_state = (rem == 6'h00) ? ST_CMD : ST_DATA;
      ST_CMD: next_state = (widx == last_w) ? ST_UPC : ST_CMD;
      ST_UPC: next_state = ST_UPD;
      ST_UPD: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // ****************************************
  // RAM: host port then engine, engine wins a collision
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (wr_rdata) begin
      ram[ram_addr[RAM_AW-1:0]] <= (ram_q & ~bmask) | (wd & bmask);
    end
    if (eng_we) begin
      ram[eng_waddr[RAM_AW-1:0]] <= eng_wdata;
    end
    ram_q <= ram[ram_addr[RAM_AW-1:0]];
    eng_q <= ram[eng_raddr[RAM_AW-1:0]];
  end

  // ****************************************
  // Engine sequencing
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      msg_ready <= 1'b0;
      word_ready <= 1'b0;
      lidx <= 4'h0;
      widx <= 3'h0;
      rem <= 6'h00;
    end else begin
      state <= next_state;
      msg_ready <= next_state == ST_IDLE && mode_ok && !msg_fire;
      word_ready <= next_state == ST_DATA && next_rem != 6'h00;
      lidx <= (state == ST_LIST) ? lidx + 4'h1 : 4'h0;
      widx <= (state == ST_CMD) ? widx + 3'h1 : 3'h0;
      rem <= next_rem;
    end
  end

  // Captured message and list copy need no reset; they are loaded before use
  always_ff @(posedge ref_clk) begin
    if (msg_fire) begin
      h_status <= msg_status;
      h_time <= msg_time;
      h_gap <= msg_gap;
      h_cmd <= msg_cmd;
      h_len <= (msg_len > MAX_DATA_WORDS) ? MAX_DATA_WORDS : msg_len;
      tt48 <= cfg[1:0] == MODE_TT48;
    end
    if (state == ST_LIST && lidx != 4'h0) begin
      list[lidx[2:0] - 3'h1] <= eng_q;
    end
    if (state == ST_LIST && lidx == LIST_LEN) begin
      cptr <= list[LW_CMD_NEXT];
      dptr <= list[LW_DAT_NEXT];
      dblk <= list[LW_DAT_NEXT];
    end else begin
      if (data_we) dptr <= dptr_inc;
      if (cmd_we) cptr <= cptr_inc;
    end
  end

  // ****************************************
  // Registers and interrupt
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg <= RST_CFG;
      list_base <= RST_LIST_BASE;
      irq_status <= RST_IRQ;
      irq_mask <= RST_IRQ;
      ram_addr <= 16'h0000;
      irq <= 1'b0;
    end else begin
      if (wr_cfg) cfg <= (cfg & ~bmask) | (wd & bmask);
      if (wr_base) list_base <= (list_base & ~bmask) | (wd & bmask);
      if (wr_imsk) irq_mask <= (irq_mask & ~bmask[2:0]) | (wd[2:0] & bmask[2:0]);
      if (wr_raddr) ram_addr <= (ram_addr & ~bmask) | (wd & bmask);
      // A new event in the clearing cycle stays set
      irq_status <= (irq_status & ~(wr_ist ? wd[2:0] & bmask[2:0] : 3'h0)) | irq_set;
      irq <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      rd_pend <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      araddr_q <= 12'h000;
    end else begin
      s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      s_axi_arready <= !rd_pend && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend <= 1'b1;
        araddr_q <= s_axi_araddr;
      end
      // One cycle pause lets the RAM read word settle on the held address
      if (rd_pend) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rmux};
        s_axi_rresp <= r_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/mcb_pkg.sv ***
// Constants shared by the monitor circular buffer manager.
// Assumes a 200 MHz single clock domain and a 16-bit word RAM.
package mcb_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG = 8'h29;
  localparam logic [7:0] IDX_LIST_BASE = 8'h2f;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  localparam logic [7:0] IDX_RAM_ADDR = 8'h32;
  localparam logic [7:0] IDX_RAM_DATA = 8'h33;
  // Time tag selection in configuration bits 1:0
  localparam logic [1:0] MODE_TT16 = 2'h3;
  localparam logic [1:0] MODE_TT48 = 2'h1;
  // Interrupt status bit positions
  localparam int IRQ_CMD_MATCH = 0;
  localparam int IRQ_DATA_MATCH = 1;
  localparam int IRQ_MSG_DONE = 2;
  // Address list word positions
  localparam logic [2:0] LW_CMD_START = 3'h0;
  localparam logic [2:0] LW_CMD_NEXT = 3'h1;
  localparam logic [2:0] LW_CMD_END = 3'h2;
  localparam logic [2:0] LW_CMD_IRQ = 3'h3;
  localparam logic [2:0] LW_DAT_START = 3'h4;
  localparam logic [2:0] LW_DAT_NEXT = 3'h5;
  localparam logic [2:0] LW_DAT_END = 3'h6;
  localparam logic [2:0] LW_DAT_IRQ = 3'h7;
  localparam logic [3:0] LIST_LEN = 4'h8;
  // Entry sizes and limits
  localparam logic [2:0] LAST_W16 = 3'h3;
  localparam logic [2:0] LAST_W48 = 3'h7;
  localparam logic [5:0] MAX_DATA_WORDS = 6'h23;
  // RAM geometry: 64K bytes of 16-bit words
  localparam int RAM_AW = 15;
  localparam int RAM_WORDS = 32768;
  // Reset values
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [15:0] RST_LIST_BASE = 16'h0000;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LIST = 3'b001,
    ST_DATA = 3'b011,
    ST_CMD = 3'b010,
    ST_UPC = 3'b110,
    ST_UPD = 3'b111
  } mcb_state_t;
endpackage

// *** verification/mcb_manager_properties.sv ***
// Port-level checks for the buffer manager.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
// ************
// Checker
// ************
module mcb_manager_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Message side
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic word_ready,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer not two cycles after take");
  a_rdata_hold: assert property (!$rose(s_axi_rvalid) |-> $stable(s_axi_rdata))
    else $error("read data changed without a new answer");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_write_excl: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_excl: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_msg_busy: assert property (msg_valid && msg_ready |=> !msg_ready [*8])
    else $error("header accepted during list fetch");
  a_words_inside: assert property (word_ready |-> !msg_ready)
    else $error("data accepted outside a message");
  a_irq_quiet: assert property ($past(rst) |-> !irq)
    else $error("interrupt high straight after reset");
endmodule
bind mcb_manager mcb_manager_properties i_props (.*);
`default_nettype wire

// *** verification/mcb_msg_source.sv ***
// Decoder stand-in feeding message headers and data words.
// Assumes the bench calls send right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
// ************
// Source
// ************
module mcb_msg_source (
  // Clock
  input wire logic ref_clk,
  // Message header
  output logic msg_valid = 1'b0,
  input wire logic msg_ready,
  output logic [15:0] msg_status = 16'h0000,
  output logic [47:0] msg_time = 48'h0,
  output logic [15:0] msg_gap = 16'h0000,
  output logic [15:0] msg_cmd = 16'h0000,
  output logic [5:0] msg_len = 6'h00,
  // Data words
  output logic word_valid = 1'b0,
  input wire logic word_ready,
  output logic [15:0] word_data = 16'h0000
);
  task automatic send(input logic [15:0] st, input logic [47:0] tm, input logic [15:0] gap,
                      input logic [15:0] cmd, input logic [5:0] len, input logic [15:0] first);
    msg_status <= st;
    msg_time <= tm;
    msg_gap <= gap;
    msg_cmd <= cmd;
    msg_len <= len;
    msg_valid <= 1'b1;
    do @(posedge ref_clk); while (!msg_ready);
    msg_valid <= 1'b0;
    // Stale status is scrambled so a late sample cannot pass
    msg_status <= ~st;
    for (int k = 0; k < len; k++) begin
      word_data <= first + 16'(k);
      word_valid <= 1'b1;
      do @(posedge ref_clk); while (!word_ready);
    end
    word_valid <= 1'b0;
    word_data <= ~word_data;
    do @(posedge ref_clk); while (!msg_ready);
  endtask
endmodule
`default_nettype wire

// *** verification/mcb_manager_bench.sv ***
// Self-checking bench for the buffer manager.
// Assumes list words and RAM are reached only through the register pair.
`timescale 1ns/100ps
`default_nettype none
// ************
// Bench
// ************
module mcb_manager_bench;
  import mcb_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic msg_valid, msg_ready, word_valid, word_ready;
  logic [15:0] msg_status, msg_gap, msg_cmd, word_data;
  logic [47:0] msg_time;
  logic [5:0] msg_len;
  int num_errors = 0, n_compared = 0;
  mcb_manager i_dut (.*);
  mcb_msg_source i_src (.*);
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] idx, input logic [15:0] d);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Spare edge so the next call never drives bready twice at once
    @(posedge ref_clk);
  endtask
  task automatic axi_rd(input logic [7:0] idx);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // Spare edge so the next call never drives rready twice at once
    @(posedge ref_clk);
  endtask
  task automatic ram_wr(input logic [15:0] a, input logic [15:0] d);
    axi_wr(IDX_RAM_ADDR, a);
    axi_wr(IDX_RAM_DATA, d);
  endtask
  task automatic ram_chk(input logic [15:0] a, input logic [15:0] e);
    axi_wr(IDX_RAM_ADDR, a);
    axi_rd(IDX_RAM_DATA);
    chk(rd, {16'h0000, e});
  endtask
  task automatic t_reset;
    axi_rd(IDX_LIST_BASE);
    chk(rd, 32'h0);
    axi_rd(8'h10);
    chk({rd[29:0], resp}, 32'h3);
    axi_wr(8'h10, 16'h1234);
    chk(resp, 32'h3);
    chk(msg_ready, 32'h0);
  endtask
  task automatic t_setup;
    logic [15:0] lst [8] = '{16'h0200, 16'h0200, 16'h020b, 16'h0205,
                             16'h0300, 16'h0300, 16'h0304, 16'h0302};
    axi_wr(IDX_LIST_BASE, 16'h0100);
    axi_rd(IDX_LIST_BASE);
    chk(rd, 32'h100);
    for (int k = 0; k < 8; k++) ram_wr(16'h0100 + 16'(k), lst[k]);
    ram_wr(16'h020c, 16'hbeef);
    ram_wr(16'h0305, 16'hbeef);
  endtask
  task automatic t_tt16;
    logic [15:0] e [20] = '{16'h0200, 16'h5001, 16'h0201, 16'h0e01, 16'h0202, 16'h0300,
      16'h0203, 16'hc001, 16'h0204, 16'h5002, 16'h0205, 16'h0e02, 16'h0206, 16'h0303,
      16'h0207, 16'hc002, 16'h0101, 16'h0208, 16'h0105, 16'h0301};
    axi_wr(IDX_CFG, {14'h0, MODE_TT16});
    i_src.send(16'h5001, 48'h0a0b_0c0d_0e01, 16'h0601, 16'hc001, 6'd3, 16'hd100);
    axi_wr(IDX_IRQ_MASK, 16'h0001);
    axi_rd(IDX_IRQ_STATUS);
    chk({rd[30:0], irq}, 32'hc);
    i_src.send(16'h5002, 48'h0a0b_0c0d_0e02, 16'h0602, 16'hc002, 6'd3, 16'hd200);
    axi_rd(IDX_IRQ_STATUS);
    chk({rd[30:0], irq}, 32'hf);
    axi_wr(IDX_IRQ_STATUS, 16'h0007);
    axi_rd(IDX_IRQ_STATUS);
    chk({rd[30:0], irq}, 32'h0);
    for (int k = 0; k < 20; k += 2) ram_chk(e[k], e[k + 1]);
  endtask
  task automatic t_tt48;
    logic [15:0] e [36] = '{16'h0208, 16'hc1c2, 16'h0209, 16'hb1b2, 16'h020a, 16'ha1a2,
      16'h020b, 16'h5003, 16'h0200, 16'h0603, 16'h0201, 16'h0004, 16'h0202, 16'h0301,
      16'h0203, 16'hc003, 16'h0204, 16'h5002, 16'h020c, 16'hbeef, 16'h0101, 16'h0204,
      16'h0105, 16'h0303, 16'h0300, 16'hd202, 16'h0301, 16'hd300, 16'h0302, 16'hd301,
      16'h0303, 16'hd200, 16'h0304, 16'hd201, 16'h0305, 16'hbeef};
    axi_wr(IDX_CFG, {14'h0, MODE_TT48});
    i_src.send(16'h5003, 48'ha1a2_b1b2_c1c2, 16'h0603, 16'hc003, 6'd2, 16'hd300);
    axi_rd(IDX_IRQ_STATUS);
    chk({rd[30:0], irq}, 32'hc);
    axi_wr(IDX_IRQ_MASK, 16'h0002);
    axi_rd(IDX_IRQ_MASK);
    chk(irq, 32'h1);
    for (int k = 0; k < 36; k += 2) ram_chk(e[k], e[k + 1]);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_reset;
    t_setup;
    t_tt16;
    t_tt48;
    give_verdict;
  end
  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
